//--- hdl/pcc_pll_clock_config.sv
// register and control logic of the loop clock configuration block
////////////////////////////////////////////////////////////////////////////////
// overview
//
// this block is the register side of the clock loop. it owns the control,
// bandwidth, multiplier, range and divider registers, keeps the lock status
// and the lock-change flag, and hands one registered configuration word to
// the analog loop. nothing here is analog: the loop itself only reports
// lock and tracking back on two level inputs.
//
// register map
//   index 0x08  loop control: enable, flag, power, base select, pre, vpr
//   index 0x09  bandwidth: auto, lock (read only), gain mode
//   index 0x0a  multiplier high, low nibble only
//   index 0x0b  multiplier low
//   index 0x0c  vco range
//   index 0x0d  reference divider, low nibble only
// the byte address is four times the index; the two low address bits must be
// zero, so a misaligned access hits nothing and reads back zero.
//
// bus timing
//   a write lands at the edge that sees the strobe; the new value is visible
//   from the next cycle. a read is decoded at the edge that sees its strobe
//   and the data stand for exactly one cycle after it, zero at all other
//   times. the master never waits, so back-to-back strobes are fine.
//
// protection
//   while power is on the programming registers and the prescale and vpr
//   bits ignore writes. power cannot drop while base select is set, and base
//   select cannot rise while power is off, the range is zero or stop is on.
//   the interlock is evaluated against the registered state, so a single
//   write cannot both switch the loop on and select its clock: software
//   needs two writes, which is what keeps a half-started loop off the bus.
//
// lock and flag
//   the lock input is taken as synchronous. it is gated by power, a nonzero
//   range, run mode and automatic bandwidth, then registered. one more flop
//   keeps the previous value; a difference between the two sets the flag.
//   the detector therefore reports a change one cycle after the lock bit
//   itself moves, and a toggle shorter than a cycle is lost by design.
//   switching automatic mode on with the loop already locked also counts as
//   a change, since the gated lock bit rises at that point.
//
// flag clearing
//   any read of the control register clears the flag, whether or not the
//   data are used. in debug halt the clear is suppressed unless the halt
//   clear enable is set; a clear made then stays after the halt ends. a new
//   lock change in the same cycle as a clearing read wins, so no event is
//   ever swallowed by a read that came too early.
//
// gain mode
//   two copies exist: the manual value written by software and the status
//   reported by the loop. reads show the status in automatic mode and the
//   manual value otherwise; the manual value is never overwritten while in
//   automatic mode, so it comes back untouched when manual mode resumes.
//
// low power
//   wait mode is ignored on purpose. stop mode forces base select low on entry,
//   or one cycle later when a control write sets it in the entry cycle, and
//   holds it low; it does not come back by itself on exit, so software must
//   select the loop clock again once lock is seen.
//
// limitations
//   the prescale and vpr values are passed through unchecked; an illegal
//   vpr code is the software's problem. zero multiplier and divider values
//   are shown to the loop as one but read back as written.
////////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the plain strobed port.
module pcc_pll_clock_config (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // register port
  input  wire logic [9:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic      [7:0]            rdata,
  // analog loop status and system modes
  input  wire logic                  loop_locked,
  input  wire logic                  loop_tracking,
  input  wire logic                  wait_mode,
  input  wire logic                  stop_mode,
  input  wire logic                  debug_halt,
  input  wire logic                  halt_flag_clear_en,
  // configuration to the analog loop and interrupt request
  output pcc_pkg::pcc_loop_cfg_t     loop_cfg,
  output logic                       loop_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                   irq_en;
    logic                   irq_flag;
    logic                   power_on;
    logic                   base_sel;
    logic [1:0]             prescale;
    logic [1:0]             vco_pow2;
    logic                   auto_bw;
    logic                   lock;
    logic                   lock_prev;
    logic                   gain_manual;
    logic                   gain_auto;
    logic [11:0]            fb_mult;
    logic [7:0]             vco_range;
    logic [3:0]             ref_div;
    pcc_pkg::pcc_mode_t     mode;
    logic                   stop_pwr_save;
    logic [7:0]             rdata;
    pcc_pkg::pcc_loop_cfg_t cfg;
    logic                   irq;
  } pcc_state_t;

  // one register for the whole block; the comb process below fills nxt_st
  // from st_ff and the inputs, so every output is a flop by construction
  pcc_state_t st_ff;
  pcc_state_t nxt_st;

  pcc_pkg::pcc_bus_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic       wr_ctrl;
    logic       wr_bw;
    logic       wr_mh;
    logic       wr_ml;
    logic       wr_vr;
    logic       wr_rd;
    logic       rd_ctrl;
    logic       lock_chg;
    logic       clr_ok;
    logic       gain_rd;
    logic       loop_run;
    logic [7:0] rd_val;
    wr_ctrl  = req.wr && (req.addr == pcc_pkg::ADDR_LOOP_CTRL);
    wr_bw    = req.wr && (req.addr == pcc_pkg::ADDR_BW_CTRL);
    wr_mh    = req.wr && (req.addr == pcc_pkg::ADDR_MULT_HIGH);
    wr_ml    = req.wr && (req.addr == pcc_pkg::ADDR_MULT_LOW);
    wr_vr    = req.wr && (req.addr == pcc_pkg::ADDR_VCO_RANGE);
    wr_rd    = req.wr && (req.addr == pcc_pkg::ADDR_REF_DIV);
    rd_ctrl  = req.rd && (req.addr == pcc_pkg::ADDR_LOOP_CTRL);
    lock_chg = 1'b0;
    clr_ok   = 1'b0;
    gain_rd  = 1'b0;
    loop_run = 1'b0;
    rd_val   = 8'h00;
    nxt_st   = st_ff;

    // wait mode is deliberately not looked at: the block carries on as is
    // software that wants the power back must clear base select and power
    // itself before waiting; the hardware keeps the loop clock available

    // stop entry: the loop is disabled and a vco-driven base clock falls back
    // to the crystal; the select is not restored on exit
    case (st_ff.mode)
      pcc_pkg::PCC_RUN: begin
        if (stop_mode) begin
          nxt_st.mode     = pcc_pkg::PCC_STOP;
          nxt_st.base_sel = 1'b0;
        end
      end
      pcc_pkg::PCC_STOP: begin
        nxt_st.base_sel = 1'b0;
        if (!stop_mode) begin
          nxt_st.mode = pcc_pkg::PCC_RUN;
        end
      end
      default: begin
        nxt_st.mode = pcc_pkg::PCC_RUN;
      end
    endcase

    // control register: power-on may not drop while base select is set, and
    // base select may not rise with power off or a zero range
    if (wr_ctrl) begin
      if (st_ff.auto_bw) begin
        nxt_st.irq_en = req.wdata[pcc_pkg::LC_IRQ_EN];
      end
      nxt_st.power_on = req.wdata[pcc_pkg::LC_POWER_ON] || st_ff.base_sel;
      if (req.wdata[pcc_pkg::LC_BASE_SEL] && st_ff.power_on &&
          (st_ff.vco_range != pcc_pkg::VCO_RANGE_OFF) &&
          (st_ff.mode == pcc_pkg::PCC_RUN)) begin
        nxt_st.base_sel = 1'b1;
      end else if (!req.wdata[pcc_pkg::LC_BASE_SEL]) begin
        nxt_st.base_sel = 1'b0;
      end
      if (!st_ff.power_on) begin
        nxt_st.prescale = req.wdata[pcc_pkg::LC_PRE_HI:pcc_pkg::LC_PRE_LO];
        nxt_st.vco_pow2 = req.wdata[pcc_pkg::LC_VPR_HI:pcc_pkg::LC_VPR_LO];
      end
    end
    if (!st_ff.auto_bw) begin
      nxt_st.irq_en = 1'b0;
    end

    // bandwidth register; the lock position write is ignored (test only)
    // the manual gain copy only moves while manual mode is in force, judged
    // on the old auto bit, so one write leaving manual mode still lands
    if (wr_bw) begin
      nxt_st.auto_bw = req.wdata[pcc_pkg::BW_AUTO];
      if (!st_ff.auto_bw) begin
        nxt_st.gain_manual = req.wdata[pcc_pkg::BW_GAIN];
      end
    end

    // programming registers are locked while the loop runs
    // changing the divider under a running loop would throw it out of lock,
    // so the writes are dropped silently instead of being queued
    if (!st_ff.power_on) begin
      if (wr_mh) begin
        nxt_st.fb_mult[11:8] = req.wdata[3:0];
      end
      if (wr_ml) begin
        nxt_st.fb_mult[7:0] = req.wdata;
      end
      if (wr_vr) begin
        nxt_st.vco_range = req.wdata;
      end
      if (wr_rd) begin
        nxt_st.ref_div = req.wdata[3:0];
      end
    end

    // a zero range clears base select and holds the loop off
    if (nxt_st.vco_range == pcc_pkg::VCO_RANGE_OFF) begin
      nxt_st.base_sel = 1'b0;
    end

    // lock tracks the loop only when powered and in automatic mode
    loop_run = st_ff.power_on && (st_ff.vco_range != pcc_pkg::VCO_RANGE_OFF) &&
               (st_ff.mode == pcc_pkg::PCC_RUN);
    nxt_st.lock      = loop_run && st_ff.auto_bw && loop_locked;
    nxt_st.lock_prev = st_ff.lock;
    nxt_st.gain_auto = loop_run && loop_tracking;
    lock_chg = st_ff.auto_bw && (st_ff.lock != st_ff.lock_prev);

    // flag: a read clears it unless break protects it; a change wins
    // the manual-mode override comes last so nothing can leave it set there
    clr_ok = rd_ctrl && (!debug_halt || halt_flag_clear_en);
    if (lock_chg) begin
      nxt_st.irq_flag = 1'b1;
    end else if (clr_ok) begin
      nxt_st.irq_flag = 1'b0;
    end
    if (!st_ff.auto_bw) begin
      nxt_st.irq_flag = 1'b0;
    end

    // read data, registered for the following cycle
    // enable, flag and lock are masked with the auto bit on the read path as
    // well, so a value left over from automatic mode is never shown
    gain_rd = st_ff.auto_bw ? st_ff.gain_auto : st_ff.gain_manual;
    if (req.rd) begin
      case (req.addr)
        pcc_pkg::ADDR_LOOP_CTRL: begin
          rd_val = {st_ff.irq_en && st_ff.auto_bw, st_ff.irq_flag && st_ff.auto_bw,
                    st_ff.power_on, st_ff.base_sel, st_ff.prescale, st_ff.vco_pow2};
        end
        pcc_pkg::ADDR_BW_CTRL: begin
          rd_val = {st_ff.auto_bw, st_ff.lock && st_ff.auto_bw, gain_rd, 5'h00};
        end
        pcc_pkg::ADDR_MULT_HIGH: begin
          rd_val = {4'h0, st_ff.fb_mult[11:8]};
        end
        pcc_pkg::ADDR_MULT_LOW: begin
          rd_val = st_ff.fb_mult[7:0];
        end
        pcc_pkg::ADDR_VCO_RANGE: begin
          rd_val = st_ff.vco_range;
        end
        pcc_pkg::ADDR_REF_DIV: begin
          rd_val = {4'h0, st_ff.ref_div};
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end
    nxt_st.rdata = rd_val;

    // configuration driven to the analog loop, zero settings act as one
    // built from nxt_st so the loop sees a register change at the write edge itself,
    // in step with the register that is read back
    nxt_st.cfg.power_on  = nxt_st.power_on && (nxt_st.vco_range != pcc_pkg::VCO_RANGE_OFF)
                           && (nxt_st.mode == pcc_pkg::PCC_RUN);
    nxt_st.cfg.base_sel  = nxt_st.base_sel;
    nxt_st.cfg.gain_mode = nxt_st.gain_manual;
    nxt_st.cfg.auto_bw   = nxt_st.auto_bw;
    nxt_st.cfg.fb_mult   = (nxt_st.fb_mult == pcc_pkg::FB_MULT_ZERO) ?
                           pcc_pkg::FB_MULT_ONE : nxt_st.fb_mult;
    nxt_st.cfg.vco_range = nxt_st.vco_range;
    nxt_st.cfg.ref_div   = (nxt_st.ref_div == pcc_pkg::REF_DIV_ZERO) ?
                           pcc_pkg::REF_DIV_ONE : nxt_st.ref_div;
    nxt_st.cfg.prescale  = nxt_st.prescale;
    nxt_st.cfg.vco_pow2  = nxt_st.vco_pow2;
    nxt_st.irq = nxt_st.irq_flag && nxt_st.irq_en && nxt_st.auto_bw;
    nxt_st.stop_pwr_save = wait_mode && 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset: power comes up on so the loop can settle early,
  // everything else starts from the documented defaults
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff               <= '0;
      st_ff.power_on      <= 1'b1;
      st_ff.prescale      <= pcc_pkg::RST_PRE;
      st_ff.vco_pow2      <= pcc_pkg::RST_VPR;
      st_ff.auto_bw       <= 1'b0;
      st_ff.gain_manual   <= 1'b0;
      st_ff.fb_mult       <= pcc_pkg::RST_FB_MULT;
      st_ff.vco_range     <= pcc_pkg::RST_VCO_RANGE;
      st_ff.ref_div       <= pcc_pkg::RST_REF_DIV;
      st_ff.mode          <= pcc_pkg::PCC_RUN;
      st_ff.cfg.power_on  <= 1'b1;
      st_ff.cfg.fb_mult   <= pcc_pkg::RST_FB_MULT;
      st_ff.cfg.vco_range <= pcc_pkg::RST_VCO_RANGE;
      st_ff.cfg.ref_div   <= pcc_pkg::RST_REF_DIV;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign rdata    = st_ff.rdata;
  assign loop_cfg = st_ff.cfg;
  assign loop_irq = st_ff.irq;

endmodule : pcc_pll_clock_config

//--- hdl/pcc_pkg.sv
// package for the loop clock configuration block: offsets, fields, reset values
package pcc_pkg;

  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_LOOP_CTRL = 8'h08;
  localparam logic [7:0] IDX_BW_CTRL   = 8'h09;
  localparam logic [7:0] IDX_MULT_HIGH = 8'h0a;
  localparam logic [7:0] IDX_MULT_LOW  = 8'h0b;
  localparam logic [7:0] IDX_VCO_RANGE = 8'h0c;
  localparam logic [7:0] IDX_REF_DIV   = 8'h0d;
  localparam logic [9:0] ADDR_LOOP_CTRL = {IDX_LOOP_CTRL, 2'b00};
  localparam logic [9:0] ADDR_BW_CTRL   = {IDX_BW_CTRL, 2'b00};
  localparam logic [9:0] ADDR_MULT_HIGH = {IDX_MULT_HIGH, 2'b00};
  localparam logic [9:0] ADDR_MULT_LOW  = {IDX_MULT_LOW, 2'b00};
  localparam logic [9:0] ADDR_VCO_RANGE = {IDX_VCO_RANGE, 2'b00};
  localparam logic [9:0] ADDR_REF_DIV   = {IDX_REF_DIV, 2'b00};

  // loop control register bit positions
  localparam int LC_IRQ_EN   = 7;
  localparam int LC_IRQ_FLAG = 6;
  localparam int LC_POWER_ON = 5;
  localparam int LC_BASE_SEL = 4;
  localparam int LC_PRE_HI   = 3;
  localparam int LC_PRE_LO   = 2;
  localparam int LC_VPR_HI   = 1;
  localparam int LC_VPR_LO   = 0;

  // bandwidth control register bit positions
  localparam int BW_AUTO = 7;
  localparam int BW_LOCK = 6;
  localparam int BW_GAIN = 5;

  // reset values
  localparam logic [11:0] RST_FB_MULT   = 12'h040;
  localparam logic [7:0]  RST_VCO_RANGE = 8'h40;
  localparam logic [3:0]  RST_REF_DIV   = 4'h1;
  localparam logic [1:0]  RST_PRE       = 2'h0;
  localparam logic [1:0]  RST_VPR       = 2'h0;

  // effective-value substitutes for zero settings
  localparam logic [11:0] FB_MULT_ZERO  = 12'h000;
  localparam logic [11:0] FB_MULT_ONE   = 12'h001;
  localparam logic [3:0]  REF_DIV_ZERO  = 4'h0;
  localparam logic [3:0]  REF_DIV_ONE   = 4'h1;
  localparam logic [7:0]  VCO_RANGE_OFF = 8'h00;

  // register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcc_bus_req_t;

  // values presented to the analog loop
  typedef struct packed {
    logic        power_on;
    logic        base_sel;
    logic        gain_mode;
    logic        auto_bw;
    logic [11:0] fb_mult;
    logic [7:0]  vco_range;
    logic [3:0]  ref_div;
    logic [1:0]  prescale;
    logic [1:0]  vco_pow2;
  } pcc_loop_cfg_t;

  // control sequence of the block; it only tracks stop entry and exit
  typedef enum logic [0:0] {
    PCC_RUN  = 1'b0,
    PCC_STOP = 1'b1
  } pcc_mode_t;

endpackage : pcc_pkg

//--- verif/pcc_pll_clock_config_props.sv
// concurrent checks on the ports of the loop clock configuration block
module pcc_pll_clock_config_props (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // register port
  input wire logic [9:0]             addr,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [7:0]             rdata,
  // loop status and modes
  input wire logic                   loop_locked,
  input wire logic                   stop_mode,
  input wire logic                   debug_halt,
  input wire logic                   halt_flag_clear_en,
  // loop configuration and request
  input wire pcc_pkg::pcc_loop_cfg_t loop_cfg,
  input wire logic                   loop_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // read of the control register with the lock input quiet, so no new flag can set
  sequence s_clear_read;
    loop_irq && rd_stb && addr == pcc_pkg::ADDR_LOOP_CTRL && !debug_halt
      && loop_locked == $past(loop_locked) && loop_locked == $past(loop_locked, 2)
      && loop_locked == $past(loop_locked, 3) ##1 $stable(loop_locked);
  endsequence
  // read in break with clearing not allowed, and no write right after
  sequence s_guarded_read;
    loop_irq && rd_stb && addr == pcc_pkg::ADDR_LOOP_CTRL && debug_halt
      && !halt_flag_clear_en ##1 !wr_stb;
  endsequence

  property p_rdata_idle;
    !rd_stb |=> rdata == 8'h00;
  endproperty
  property p_irq_manual;
    !loop_cfg.auto_bw ##1 !loop_cfg.auto_bw |-> !loop_irq;
  endproperty
  property p_zero_as_one;
    loop_cfg.fb_mult != 12'h000 && loop_cfg.ref_div != 4'h0;
  endproperty
  property p_base_range;
    loop_cfg.base_sel |-> loop_cfg.vco_range != 8'h00;
  endproperty
  property p_stop_base;
    stop_mode |=> !loop_cfg.base_sel;
  endproperty
  property p_frozen;
    loop_cfg.power_on && wr_stb |=>
      $stable({loop_cfg.fb_mult, loop_cfg.vco_range, loop_cfg.ref_div});
  endproperty
  property p_flag_clear;
    s_clear_read |=> !loop_irq;
  endproperty
  property p_halt_keep;
    s_guarded_read |=> loop_irq;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_irq_manual: assert property (p_irq_manual) else $error("request in manual mode");
  a_zero_as_one: assert property (p_zero_as_one) else $error("zero divider shown");
  a_base_range: assert property (p_base_range) else $error("base select with range zero");
  a_stop_base: assert property (p_stop_base) else $error("base select kept in stop");
  a_frozen: assert property (p_frozen) else $error("loop setting changed while on");
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept after read");
  a_halt_keep: assert property (p_halt_keep) else $error("flag lost in break");
endmodule : pcc_pll_clock_config_props

bind pcc_pll_clock_config pcc_pll_clock_config_props u_props (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .loop_locked(loop_locked), .stop_mode(stop_mode), .debug_halt(debug_halt),
  .halt_flag_clear_en(halt_flag_clear_en), .loop_cfg(loop_cfg), .loop_irq(loop_irq));

//--- verif/pll_clock_config_bench.sv
// self-checking bench of the loop clock configuration block
module pll_clock_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] A_LC = pcc_pkg::ADDR_LOOP_CTRL;
  localparam logic [9:0] A_BW = pcc_pkg::ADDR_BW_CTRL;
  localparam logic [9:0] A_MH = pcc_pkg::ADDR_MULT_HIGH;
  localparam logic [9:0] A_ML = pcc_pkg::ADDR_MULT_LOW;
  localparam logic [9:0] A_VR = pcc_pkg::ADDR_VCO_RANGE;
  localparam logic [9:0] A_RD = pcc_pkg::ADDR_REF_DIV;
  // rows: address, write flag, write data, expected read back
  localparam logic [26:0] ROWS [16] = '{
    {A_LC, 9'h000, 8'h20}, {A_BW, 9'h000, 8'h00}, {A_MH, 9'h000, 8'h00},
    {A_ML, 9'h000, 8'h40}, {A_VR, 9'h000, 8'h40}, {A_RD, 9'h000, 8'h01},
    {10'h3fc, 9'h000, 8'h00}, {A_ML, 9'h155, 8'h40}, {A_LC, 9'h180, 8'h00},
    {A_MH, 9'h1ff, 8'h0f}, {A_MH, 9'h1f0, 8'h00}, {A_ML, 9'h100, 8'h00},
    {A_RD, 9'h1f0, 8'h00}, {A_VR, 9'h155, 8'h55}, {A_BW, 9'h180, 8'h80},
    {A_BW, 9'h100, 8'h00}};
  logic                   clk;
  logic                   rst_b;
  logic [9:0]             addr;
  logic [7:0]             wdata;
  logic                   wr_stb;
  logic                   rd_stb;
  logic [7:0]             rdata;
  logic                   loop_locked;
  logic                   loop_tracking;
  logic                   wait_mode;
  logic                   stop_mode;
  logic                   debug_halt;
  logic                   halt_flag_clear_en;
  pcc_pkg::pcc_loop_cfg_t loop_cfg;
  logic                   loop_irq;
  int                     bad_count;
  int                     checks_done;
  int                     cycles;

  pcc_pll_clock_config u_dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .loop_locked(loop_locked), .loop_tracking(loop_tracking),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .debug_halt(debug_halt),
    .halt_flag_clear_en(halt_flag_clear_en), .loop_cfg(loop_cfg), .loop_irq(loop_irq));

  ////////////////////////////////////////////////////////////////////////////////
  // compare and count; x never passes for a match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle write, returns once the write edge has landed
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  // one-cycle read; data stand only in the following cycle
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(16'(rdata), 16'(e));
  endtask : rc
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; a full run needs well under a thousand cycles
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    {addr, wdata, wr_stb, rd_stb, loop_locked, loop_tracking, wait_mode} = '0;
    {stop_mode, debug_halt, halt_flag_clear_en, rst_b} = '0;
    {bad_count, checks_done, cycles} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (ROWS[i][16]) wr(ROWS[i][26:17], ROWS[i][15:8]);
      rc(ROWS[i][26:17], ROWS[i][7:0]);
    end
    chk(16'(loop_cfg.fb_mult), 16'h0001);
    chk(16'(loop_cfg.ref_div), 16'h0001);
    chk(16'(loop_cfg.vco_range), 16'h0055);
    // base select refused with range zero, allowed unlocked otherwise
    wr(A_VR, 8'h00);
    wr(A_LC, 8'h20);
    wr(A_LC, 8'h30);
    rc(A_LC, 8'h20);
    chk(16'(loop_cfg.power_on), 16'h0000);
    wr(A_LC, 8'h00);
    wr(A_LC, 8'h09);
    chk(16'(loop_cfg.prescale), 16'h0002);
    chk(16'(loop_cfg.vco_pow2), 16'h0001);
    wr(A_LC, 8'h00);
    wr(A_VR, 8'h40);
    wr(A_RD, 8'h01);
    rc(A_RD, 8'h01);
    wr(A_LC, 8'h20);
    wr(A_LC, 8'h30);
    rc(A_LC, 8'h30);
    chk(16'(loop_cfg.base_sel), 16'h0001);
    wait_mode <= 1'b1;
    idle(3);
    wait_mode <= 1'b0;
    rc(A_LC, 8'h30);
    stop_mode <= 1'b1;
    idle(3);
    chk(16'(loop_cfg.power_on), 16'h0000);
    chk(16'(loop_cfg.base_sel), 16'h0000);
    stop_mode <= 1'b0;
    rc(A_LC, 8'h20);
    // manual gain value survives auto mode; auto mode shows loop status
    wr(A_BW, 8'h20);
    rc(A_BW, 8'h20);
    wr(A_BW, 8'ha0);
    wr(A_BW, 8'h80);
    chk(16'(loop_cfg.gain_mode), 16'h0001);
    loop_tracking <= 1'b1;
    rc(A_BW, 8'ha0);
    loop_tracking <= 1'b0;
    rc(A_BW, 8'h80);
    // lock change sets the flag; reads clear it except in guarded break
    wr(A_LC, 8'ha0);
    rc(A_LC, 8'ha0);
    loop_locked <= 1'b1;
    idle(4);
    chk(16'(loop_irq), 16'h0001);
    rc(A_BW, 8'hc0);
    rc(A_LC, 8'he0);
    rc(A_LC, 8'ha0);
    debug_halt  <= 1'b1;
    loop_locked <= 1'b0;
    idle(4);
    rc(A_LC, 8'he0);
    rc(A_LC, 8'he0);
    halt_flag_clear_en <= 1'b1;
    rc(A_LC, 8'he0);
    rc(A_LC, 8'ha0);
    debug_halt         <= 1'b0;
    halt_flag_clear_en <= 1'b0;
    rc(A_LC, 8'ha0);
    // manual mode hides flag, enable and lock; manual gain comes back
    loop_locked <= 1'b1;
    idle(4);
    wr(A_BW, 8'h00);
    idle(2);
    chk(16'(loop_irq), 16'h0000);
    rc(A_LC, 8'h20);
    rc(A_BW, 8'h20);
    // reset in mid-run, then lock forced low by power off
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    idle(1);
    chk(16'(loop_cfg.fb_mult), 16'h0040);
    chk(16'(loop_cfg.vco_range), 16'h0040);
    rc(A_BW, 8'h00);
    wr(A_BW, 8'h80);
    idle(2);
    rc(A_BW, 8'hc0);
    wr(A_LC, 8'h00);
    idle(1);
    rc(A_BW, 8'h80);
    report_and_stop();
  end
endmodule : pll_clock_config_bench
